//--- ccp_pkg.sv
package ccp_pkg;
  // Register word offsets (byte addresses)
  localparam logic [11:0] ctrl_off = 12'h000;
  localparam logic [11:0] data_low_off = 12'h004;
  localparam logic [11:0] data_high_off = 12'h008;
  localparam logic [11:0] status_off = 12'h00C;
  localparam logic [11:0] tsel_off = 12'h010;
  // Field positions
  localparam int mode_lsb = 0;
  localparam int duty_lsb = 4;
  localparam int flag_bit = 0;
  localparam int irq_en_bit = 1;
  localparam int cmp_out_bit = 2;
  // Reset values
  localparam logic [7:0] ctrl_rst = 8'h00;
  localparam logic [7:0] data_rst = 8'h00;
  localparam logic [1:0] tsel_rst = 2'h0;
  // Prescale counts
  localparam logic [3:0] presc_div4 = 4'h3;
  localparam logic [3:0] presc_div16 = 4'hF;
  // Mode codes
  localparam logic [3:0] m_off = 4'h0;
  localparam logic [3:0] m_toggle = 4'h2;
  localparam logic [3:0] m_fall = 4'h4;
  localparam logic [3:0] m_rise = 4'h5;
  localparam logic [3:0] m_rise4 = 4'h6;
  localparam logic [3:0] m_rise16 = 4'h7;
  localparam logic [3:0] m_set_hi = 4'h8;
  localparam logic [3:0] m_set_lo = 4'h9;
  localparam logic [3:0] m_soft = 4'hA;
  localparam logic [3:0] m_special = 4'hB;
  typedef enum logic [1:0] {cls_off, cls_capture, cls_compare, cls_pwm} mode_class_e;
endpackage

//--- pin_sync_edge.sv
`timescale 1ns/1ps
module pin_sync_edge (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Pin sample and edges
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
endmodule

//--- capture_compare_pwm_control.sv
// Functional notes
// - Control bits 7-6 read zero, ignore writes
// - Bits 5-4 are PWM duty low bits
// - Mode 0000 disables and resets channel
// - Mode 0010 toggles output, sets flag
// - Modes 0100-0111 select capture edge/prescale
// - Mode 1000 starts low, match forces high
// - Mode 1001 starts high, match forces low
// - Mode 1010 sets flag only, pin is latch
// - Mode 1011 fires special event trigger
// - Special trigger clears assigned timer counter
// - Modes 11xx are PWM on timer two/four
// - Data register is two RW bytes
// - Capture/compare use timer one or three
// - Timer assignment chooses one of four
// - Assignment splits enhanced channels between pairs
// - Capture copies 16-bit assigned timer count
// - Capture sets flag, software clears it
// - New capture overwrites unread data
// - Pin sampled even when driven as output
// - Mode change may raise false flag
// - Prescaler cleared on off, leaving capture
// - Prescale switch keeps counter, may flag
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module capture_compare_pwm_control #(
  parameter int channel_index = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel pin and port latch
  input wire logic channel_pin,
  input wire logic port_latch,
  output logic pin_out,
  // Shared timers
  input wire logic [15:0] first_timer_count,
  input wire logic [15:0] third_timer_count,
  input wire logic timer_pwm_tick_second,
  input wire logic timer_pwm_tick_fourth,
  // Outputs to system
  output logic special_trigger,
  output logic clear_first_timer,
  output logic clear_third_timer,
  output logic pwm_uses_fourth,
  output logic [9:0] pwm_duty
);
  import ccp_pkg::*;

  logic [5:0] ctrl_r;
  logic [7:0] data_low_r;
  logic [7:0] data_high_r;
  logic flag_r;
  logic irq_en_r;
  logic [1:0] tsel_r;
  logic cmp_out_r;
  logic [3:0] presc_r;
  logic [3:0] prev_mode_r;
  logic match_seen_r;
  logic rise;
  logic fall;
  logic [3:0] mode;
  mode_class_e cls;
  logic use_third;
  logic [15:0] tbase;
  logic wr_en;
  logic rd_en;
  logic cap_event;
  logic cmp_match;
  logic capture_mode;

  // ==========================================================
  // Mode decode and time base
  assign mode = ctrl_r[mode_lsb +: 4];
  assign capture_mode = (mode[3:2] == 2'b01);
  always_comb begin
    if (mode == m_off || mode == 4'h1 || mode == 4'h3) begin
      cls = cls_off;
    end else if (capture_mode) begin
      cls = cls_capture;
    end else if (mode[3:2] == 2'b11) begin
      cls = cls_pwm;
    end else begin
      cls = cls_compare;
    end
  end

  // Assignment: 0 all first pair, 1 only channel one, 2 channels one-two, 3 all third pair
  always_comb begin
    case (tsel_r)
      2'd0: use_third = 1'b0;
      2'd1: use_third = (channel_index > 1);
      2'd2: use_third = (channel_index > 2);
      default: use_third = 1'b1;
    endcase
  end
  assign tbase = use_third ? third_timer_count : first_timer_count;

  // ==========================================================
  // Pin edge detection
  pin_sync_edge pin_sync_edge_i (
    .clock(clock),
    .rstn(rstn),
    .pin(channel_pin),
    .rise(rise),
    .fall(fall)
  );

  // ==========================================================
  // APB access
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr == ctrl_off || paddr == data_low_off ||
                 paddr == data_high_off || paddr == status_off || paddr == tsel_off);
      if (rd_en) begin
        if (paddr == ctrl_off) begin
          prdata <= {26'h0, ctrl_r};
        end else if (paddr == data_low_off) begin
          prdata <= {24'h0, data_low_r};
        end else if (paddr == data_high_off) begin
          prdata <= {24'h0, data_high_r};
        end else if (paddr == status_off) begin
          prdata <= {29'h0, cmp_out_r, irq_en_r, flag_r};
        end else if (paddr == tsel_off) begin
          prdata <= {30'h0, tsel_r};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= ctrl_rst[5:0];
      tsel_r <= tsel_rst;
      irq_en_r <= 1'b0;
    end else if (wr_en && pready) begin
      if (paddr == ctrl_off) begin
        ctrl_r <= pwdata[5:0];
      end else if (paddr == tsel_off) begin
        tsel_r <= pwdata[1:0];
      end else if (paddr == status_off) begin
        irq_en_r <= pwdata[irq_en_bit];
      end
    end
  end

  // ==========================================================
  // Capture and compare
  logic [3:0] presc_lim;
  always_comb begin
    case (mode)
      m_rise4: presc_lim = presc_div4;
      m_rise16: presc_lim = presc_div16;
      default: presc_lim = 4'h0;
    endcase
  end

  logic edge_hit;
  assign edge_hit = (mode == m_fall) ? fall : rise;
  assign cap_event = capture_mode && edge_hit && (presc_r >= presc_lim);
  assign cmp_match = (cls == cls_compare) && ({data_high_r, data_low_r} == tbase);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      presc_r <= 4'h0;
    end else if (!capture_mode) begin
      presc_r <= 4'h0;
    end else if (edge_hit) begin
      presc_r <= (presc_r >= presc_lim) ? 4'h0 : presc_r + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prev_mode_r <= 4'h0;
      match_seen_r <= 1'b0;
    end else begin
      prev_mode_r <= mode;
      match_seen_r <= cmp_match;
    end
  end

  logic match_pulse;
  assign match_pulse = cmp_match & ~match_seen_r;

  // Data register: capture wins over software write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_low_r <= data_rst;
      data_high_r <= data_rst;
    end else if (cap_event) begin
      {data_high_r, data_low_r} <= tbase;
    end else if (wr_en && pready) begin
      if (paddr == data_low_off) begin
        data_low_r <= pwdata[7:0];
      end else if (paddr == data_high_off) begin
        data_high_r <= pwdata[7:0];
      end
    end
  end

  // Event flag: set wins over clear; mode changes may also flag
  logic cap_switch;
  assign cap_switch = capture_mode && (prev_mode_r[3:2] == 2'b01) && (prev_mode_r != mode);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flag_r <= 1'b0;
    end else if (cap_event || match_pulse || cap_switch) begin
      flag_r <= 1'b1;
    end else if (wr_en && pready && paddr == status_off && pwdata[flag_bit]) begin
      flag_r <= 1'b0;
    end
  end

  // Compare output latch
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmp_out_r <= 1'b0;
    end else if (mode == m_off) begin
      cmp_out_r <= 1'b0;
    end else if (mode != prev_mode_r && mode == m_set_hi) begin
      cmp_out_r <= 1'b0;
    end else if (mode != prev_mode_r && mode == m_set_lo) begin
      cmp_out_r <= 1'b1;
    end else if (match_pulse) begin
      if (mode == m_toggle) begin
        cmp_out_r <= ~cmp_out_r;
      end else if (mode == m_set_hi) begin
        cmp_out_r <= 1'b1;
      end else if (mode == m_set_lo) begin
        cmp_out_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Outputs
  logic pin_nxt;
  always_comb begin
    if (mode == m_toggle || mode == m_set_hi || mode == m_set_lo) begin
      pin_nxt = cmp_out_r;
    end else begin
      pin_nxt = port_latch;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 1'b0;
      special_trigger <= 1'b0;
      clear_first_timer <= 1'b0;
      clear_third_timer <= 1'b0;
      pwm_uses_fourth <= 1'b0;
      pwm_duty <= 10'h000;
    end else begin
      pin_out <= pin_nxt;
      special_trigger <= match_pulse && mode == m_special;
      clear_first_timer <= match_pulse && mode == m_special && !use_third;
      clear_third_timer <= match_pulse && mode == m_special && use_third;
      pwm_uses_fourth <= (cls == cls_pwm) && use_third;
      pwm_duty <= (cls == cls_pwm) ? {data_low_r, ctrl_r[duty_lsb +: 2]} : 10'h000;
    end
  end

  // ==========================================================
  // Assertions
  a_ctrl_top_zero: assert property (@(posedge clock) disable iff (!rstn)
    (pready && !pwrite && $past(paddr) == ctrl_off) |-> prdata[7:6] == 2'b00)
    else $error("control top bits not zero");
  a_capture_copies: assert property (@(posedge clock) disable iff (!rstn)
    cap_event |=> {data_high_r, data_low_r} == $past(tbase))
    else $error("capture value wrong");
  a_capture_flag: assert property (@(posedge clock) disable iff (!rstn)
    cap_event |=> flag_r)
    else $error("capture did not set flag");
  a_off_clears: assert property (@(posedge clock) disable iff (!rstn)
    (mode == m_off) |=> presc_r == 4'h0 && cmp_out_r == 1'b0)
    else $error("off mode did not reset");
  a_presc_clear: assert property (@(posedge clock) disable iff (!rstn)
    !capture_mode |=> presc_r == 4'h0)
    else $error("prescaler not cleared");
  a_special_clear: assert property (@(posedge clock) disable iff (!rstn)
    (match_pulse && mode == m_special) |=> (clear_first_timer ^ clear_third_timer))
    else $error("special trigger without timer clear");
  a_toggle_out: assert property (@(posedge clock) disable iff (!rstn)
    (match_pulse && mode == m_toggle && mode == prev_mode_r) |=> cmp_out_r != $past(cmp_out_r))
    else $error("toggle missed");
  a_pwm_duty: assert property (@(posedge clock) disable iff (!rstn)
    (cls == cls_pwm) |=> pwm_duty == {$past(data_low_r), $past(ctrl_r[5:4])})
    else $error("pwm duty wrong");
  a_rise16_count: assert property (@(posedge clock) disable iff (!rstn)
    (mode == m_rise16 && cap_event) |-> presc_r == 4'hF)
    else $error("sixteenth edge count wrong");
  // First cycle of a compare equality
  sequence s_first_match;
    cmp_match && !match_seen_r;
  endsequence
  a_match_flag: assert property (@(posedge clock) disable iff (!rstn)
    s_first_match |=> flag_r)
    else $error("compare match did not set flag");
endmodule

//--- pin_source.sv
`timescale 1ns/1ps
module pin_source (
  // Clock
  input wire logic clock,
  // Commands from the bench
  input wire logic level,
  input wire logic slow,
  // Driven pin
  output logic channel_pin
);
  logic [2:0] lag_r = 3'h0;
  logic pin_r = 1'b0;
  // Pin follows the command one edge later, three more when slow
  always @(posedge clock) begin
    lag_r <= {lag_r[1:0], level};
    pin_r <= slow ? lag_r[2] : level;
  end
  assign channel_pin = pin_r;
endmodule

//--- capture_compare_pwm_control_tb_top.sv
`timescale 1ns/1ps
module capture_compare_pwm_control_tb_top;
  import ccp_pkg::*;
  logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, v;
  logic pready, pslverr, ev, channel_pin, port_latch = 1, pin_out, level = 0, slow = 0;
  logic [15:0] t1 = '0, t3 = '0;
  logic special_trigger, clear_first_timer, clear_third_timer, pwm_uses_fourth;
  logic [9:0] pwm_duty;
  logic [2:0] seen = '0;
  logic [3:0] cm [5] = '{m_toggle, m_set_hi, m_set_lo, m_soft, m_special};
  logic [4:0] pb = 5'b11100, pa = 5'b11011;
  int err_total = 0, checks_done = 0;
  // ==========
  // Clock, design and pin source
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) if (rstn) seen <= seen | {special_trigger, clear_first_timer,
    clear_third_timer};
  capture_compare_pwm_control capture_compare_pwm_control_i (.clock(clock), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_pin(channel_pin),
    .port_latch(port_latch), .pin_out(pin_out), .first_timer_count(t1),
    .third_timer_count(t3), .timer_pwm_tick_second(1'b0), .timer_pwm_tick_fourth(1'b0),
    .special_trigger(special_trigger), .clear_first_timer(clear_first_timer),
    .clear_third_timer(clear_third_timer), .pwm_uses_fourth(pwm_uses_fourth),
    .pwm_duty(pwm_duty));
  pin_source pin_source_i (.clock(clock), .level(level), .slow(slow),
    .channel_pin(channel_pin));
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    v = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(v & m, e);
  endtask
  task automatic setl(input logic l);
    level <= l;
    repeat (10) @(posedge clock);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      setl(1'b1);
      setl(1'b0);
    end
  endtask
  task automatic presc(input logic [3:0] md, input int pre, input int n);
    wr(ctrl_off, 32'h0);
    wr(ctrl_off, {28'h0, md});
    if (pre > 0) begin
      pulse(pre);
      wr(ctrl_off, 32'h0);
      wr(ctrl_off, {28'h0, md});
    end
    wr(status_off, 32'h1);
    pulse(n - 1);
    rdc(status_off, 32'h1, 32'h0);
    pulse(1);
    rdc(status_off, 32'h1, 32'h1);
  endtask
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========
  // Watchdog
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    wrap_up();
  end
  // ==========
  // Tests
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1;
    rdc(ctrl_off, 32'hFF, 32'h0);
    wr(ctrl_off, 32'hFF);
    rdc(ctrl_off, 32'hFF, 32'h3F);
    wr(data_low_off, 32'hA5);
    wr(data_high_off, 32'h5A);
    rdc(data_low_off, 32'hFF, 32'hA5);
    rdc(data_high_off, 32'hFF, 32'h5A);
    rdc(12'h014, 32'hFFFF_FFFF, 32'h0);
    chk(ev, 1);
    wr(status_off, 32'h2);
    rdc(status_off, 32'h6, 32'h2);
    wr(ctrl_off, 32'h3C);
    wr(data_low_off, 32'h96);
    wr(tsel_off, 32'h3);
    repeat (3) @(posedge clock);
    chk(pwm_duty, 10'h25B);
    chk(pwm_uses_fourth, 1);
    wr(ctrl_off, 32'h0);
    repeat (3) @(posedge clock);
    chk(pwm_duty, 0);
    t1 <= 16'h1357;
    t3 <= 16'h2468;
    wr(tsel_off, 32'h0);
    wr(ctrl_off, {28'h0, m_rise});
    wr(status_off, 32'h1);
    pulse(1);
    rdc(data_low_off, 32'hFF, 32'h57);
    rdc(data_high_off, 32'hFF, 32'h13);
    repeat (20) @(posedge clock);
    rdc(status_off, 32'h1, 32'h1);
    t3 <= 16'hCAFE;
    wr(tsel_off, 32'h3);
    pulse(1);
    rdc(data_low_off, 32'hFF, 32'hFE);
    rdc(data_high_off, 32'hFF, 32'hCA);
    wr(tsel_off, 32'h2);
    pulse(1);
    rdc(data_high_off, 32'hFF, 32'h13);
    wr(tsel_off, 32'h1);
    rdc(tsel_off, 32'h3, 32'h1);
    pulse(1);
    rdc(data_high_off, 32'hFF, 32'hCA);
    wr(status_off, 32'h1);
    rdc(status_off, 32'h1, 32'h0);
    wr(ctrl_off, {28'h0, m_fall});
    wr(status_off, 32'h1);
    setl(1'b1);
    rdc(status_off, 32'h1, 32'h0);
    setl(1'b0);
    rdc(status_off, 32'h1, 32'h1);
    presc(m_rise4, 0, 4);
    slow <= 1;
    presc(m_rise16, 0, 16);
    slow <= 0;
    presc(m_rise4, 2, 4);
    wr(status_off, 32'h1);
    pulse(2);
    wr(ctrl_off, {28'h0, m_rise16});
    rdc(status_off, 32'h1, 32'h1);
    wr(status_off, 32'h1);
    pulse(13);
    rdc(status_off, 32'h1, 32'h0);
    pulse(1);
    rdc(status_off, 32'h1, 32'h1);
    wr(tsel_off, 32'h0);
    for (int i = 0; i < 5; i++) begin
      t1 <= '0;
      wr(ctrl_off, 32'h0);
      wr(data_low_off, 32'h34);
      wr(data_high_off, 32'h12);
      wr(status_off, 32'h1);
      wr(ctrl_off, {28'h0, cm[i]});
      repeat (3) @(posedge clock);
      chk(pin_out, pb[i]);
      t1 <= 16'h1234;
      repeat (4) @(posedge clock);
      chk(pin_out, pa[i]);
      rdc(status_off, 32'h1, 32'h1);
    end
    chk(seen, 3'b110);
    wrap_up();
  end
endmodule
